//--- rtl/scs_exec.sv
`timescale 1ns/1ps
// How it works
// RQ1: Compare-immediate spans two words, two cycles; immediate comes from the second word.
// RQ2: Accumulator equal to immediate (0 to 15) skips the next instruction.
// RQ3: Unequal compare runs the next instruction normally; carry unchanged.
// RQ4: Set-indexed-port-bit drives bit Y of the port high in one cycle.
// RQ5: Program must keep Y within 0 to 7 for set-indexed-port-bit.
// RQ6: Set-carry sets carry, set-single-port sets port C; one cycle, no skip.
module scs_exec (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  // Instruction stream, one valid word per instruction cycle
  input scs_pkg::scs_instr_type INSTR,
  // Core registers
  input wire logic [3:0] ACC,
  input wire logic [3:0] YPTR,
  // Flag and ports
  output logic CARRY_FLAG,
  output logic SET_SINGLE_PORT,
  output logic [7:0] INDEXED_PORT,
  // Sequencing
  output logic OPERAND_WAIT,
  output logic SKIP_PENDING,
  output logic SKIPPED
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  scs_pkg::scs_op_type op;
  scs_pkg::scs_state_type state_reg;
  scs_pkg::scs_state_type state_next;
  logic skip_reg;
  logic skipped_reg;
  logic carry_reg;
  logic port_c_reg;
  logic [7:0] port_d_reg;
  logic run;
  logic operand_ok;
  logic equal;

  scs_op_decode scs_op_decode_i (
    .word(INSTR.word),
    .op(op)
  );

  // Word taken for execution: valid, not being skipped, not an operand
  assign run = INSTR.valid && !skip_reg && (state_reg == scs_pkg::ST_FETCH);
  assign operand_ok = INSTR.valid && (state_reg == scs_pkg::ST_OPERAND);
  assign equal = (ACC == INSTR.word[3:0]);

  // ----------------------------------------
  // Compare sequence
  // ----------------------------------------
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      scs_pkg::ST_FETCH:
      begin
        // RQ1: first word opens operand cycle
        if (run && op == scs_pkg::OP_COMPARE_IMMEDIATE_SKIP)
        begin
          state_next = scs_pkg::ST_OPERAND;
        end
      end
      scs_pkg::ST_OPERAND:
      begin
        if (INSTR.valid)
        begin
          state_next = scs_pkg::ST_FETCH;
        end
      end
      default:
      begin
        state_next = scs_pkg::ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      state_reg <= scs_pkg::ST_FETCH;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Skip control
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      skip_reg <= 1'h0;
    end
    // RQ2: equal immediate arms a skip
    else if (operand_ok && equal)
    begin
      skip_reg <= 1'h1;
    end
    // RQ3: unequal or consumed word leaves no skip
    else if (INSTR.valid)
    begin
      skip_reg <= 1'h0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      skipped_reg <= 1'h0;
    end
    else
    begin
      skipped_reg <= INSTR.valid && skip_reg;
    end
  end

  // ----------------------------------------
  // Carry flag
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      carry_reg <= scs_pkg::RST_CARRY;
    end
    // RQ6: set carry
    else if (run && op == scs_pkg::OP_SET_CARRY)
    begin
      carry_reg <= 1'h1;
    end
  end

  // ----------------------------------------
  // Output ports
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      port_c_reg <= scs_pkg::RST_PORT_C;
    end
    // RQ6: set single port
    else if (run && op == scs_pkg::OP_SET_SINGLE_PORT)
    begin
      port_c_reg <= 1'h1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      port_d_reg <= scs_pkg::RST_PORT_D;
    end
    // RQ4: set bit chosen by Y
    // RQ5: Y above 7 leaves the port untouched
    else if (run && op == scs_pkg::OP_SET_INDEXED_PORT_BIT && YPTR <= 4'(scs_pkg::YPTR_MAX))
    begin
      port_d_reg[YPTR[2:0]] <= 1'h1;
    end
  end

  assign CARRY_FLAG = carry_reg;
  assign SET_SINGLE_PORT = port_c_reg;
  assign INDEXED_PORT = port_d_reg;
  assign OPERAND_WAIT = (state_reg == scs_pkg::ST_OPERAND);
  assign SKIP_PENDING = skip_reg;
  assign SKIPPED = skipped_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);

  a_compare_two_words: assert property ( // RQ1
    (run && op == scs_pkg::OP_COMPARE_IMMEDIATE_SKIP) |=> OPERAND_WAIT && !SKIP_PENDING
  ) else $error("compare did not wait for its operand");

  a_equal_skips: assert property ( // RQ2
    (operand_ok && equal) |=> SKIP_PENDING ##0 (!OPERAND_WAIT)
  ) else $error("equal compare did not arm a skip");

  a_skip_consumes_word: assert property ( // RQ2
    (SKIP_PENDING && INSTR.valid && op == scs_pkg::OP_SET_CARRY && !CARRY_FLAG) |=> SKIPPED && !CARRY_FLAG
  ) else $error("skipped word was executed");

  a_unequal_no_skip: assert property ( // RQ3
    (operand_ok && !equal) |=> !SKIP_PENDING && $stable(CARRY_FLAG)
  ) else $error("unequal compare skipped or changed carry");

  a_indexed_bit_set: assert property ( // RQ4
    (run && op == scs_pkg::OP_SET_INDEXED_PORT_BIT && YPTR < 4'h8) |=> INDEXED_PORT[$past(YPTR[2:0])]
  ) else $error("indexed port bit not set");

  a_carry_set: assert property ( // RQ6
    (run && op == scs_pkg::OP_SET_CARRY) |=> CARRY_FLAG && !SKIP_PENDING && !OPERAND_WAIT
  ) else $error("carry not set in one cycle");

  a_port_c_set: assert property ( // RQ6
    (run && op == scs_pkg::OP_SET_SINGLE_PORT) |=> SET_SINGLE_PORT && !SKIP_PENDING
  ) else $error("single port not set in one cycle");

  a_carry_sticky: assert property ( // RQ6
    CARRY_FLAG |=> CARRY_FLAG
  ) else $error("carry dropped without reset");

endmodule : scs_exec

//--- include/scs_pkg.sv
package scs_pkg;

  // ----------------------------------------
  // Word and field sizes
  // ----------------------------------------
  localparam int WORD_W = 10;
  localparam int NIBBLE_W = 4;
  localparam int PORT_D_W = 8;
  localparam int YPTR_MAX = 7;

  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [9:0] OPC_SET_CARRY = 10'h007;
  localparam logic [9:0] OPC_SET_SINGLE_PORT = 10'h28D;
  localparam logic [9:0] OPC_SET_INDEXED_PORT_BIT = 10'h015;
  localparam logic [9:0] OPC_COMPARE_IMMEDIATE_SKIP = 10'h025;
  localparam logic [5:0] OPC_IMMEDIATE_PREFIX = 6'h07;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic RST_CARRY = 1'h0;
  localparam logic RST_PORT_C = 1'h0;
  localparam logic [7:0] RST_PORT_D = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [9:0] word;
  } scs_instr_type;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_SET_CARRY = 3'b001,
    OP_SET_SINGLE_PORT = 3'b010,
    OP_SET_INDEXED_PORT_BIT = 3'b011,
    OP_COMPARE_IMMEDIATE_SKIP = 3'b100
  } scs_op_type;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_OPERAND = 2'b01
  } scs_state_type;

endpackage : scs_pkg

//--- rtl/scs_op_decode.sv
`timescale 1ns/1ps
module scs_op_decode (
  // Instruction word
  input wire logic [9:0] word,
  // Decoded operation
  output scs_pkg::scs_op_type op
);

  always_comb
  begin
    if (word == scs_pkg::OPC_SET_CARRY)
    begin
      op = scs_pkg::OP_SET_CARRY;
    end
    else if (word == scs_pkg::OPC_SET_SINGLE_PORT)
    begin
      op = scs_pkg::OP_SET_SINGLE_PORT;
    end
    else if (word == scs_pkg::OPC_SET_INDEXED_PORT_BIT)
    begin
      op = scs_pkg::OP_SET_INDEXED_PORT_BIT;
    end
    else if (word == scs_pkg::OPC_COMPARE_IMMEDIATE_SKIP)
    begin
      op = scs_pkg::OP_COMPARE_IMMEDIATE_SKIP;
    end
    else
    begin
      op = scs_pkg::OP_NONE;
    end
  end

endmodule : scs_op_decode

//--- test/scs_testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_total++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk;
  logic sys_rst;
  scs_pkg::scs_instr_type instr;
  logic [3:0] acc;
  logic [3:0] yptr;
  logic [3:0] acc_set;
  logic [3:0] yptr_set;
  logic carry_flag;
  logic set_single_port;
  logic [7:0] indexed_port;
  logic operand_wait;
  logic skip_pending;
  logic skipped;
  int err_total;
  int n_compared;

  scs_exec scs_exec_i (
    .CORE_CLK(core_clk),
    .SYS_RST(sys_rst),
    .INSTR(instr),
    .ACC(acc),
    .YPTR(yptr),
    .CARRY_FLAG(carry_flag),
    .SET_SINGLE_PORT(set_single_port),
    .INDEXED_PORT(indexed_port),
    .OPERAND_WAIT(operand_wait),
    .SKIP_PENDING(skip_pending),
    .SKIPPED(skipped)
  );

  initial
  begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic put(input logic v, input logic [9:0] w);
    @(negedge core_clk);
    instr = '{valid: v, word: w};
    acc = acc_set;
    yptr = yptr_set;
    @(posedge core_clk);
    #1;
  endtask : put

  task automatic give_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic test_compare;
    for (int n = 0; n < 16; n++)
    begin
      acc_set = 4'(n);
      put(1'h1, scs_pkg::OPC_COMPARE_IMMEDIATE_SKIP);
      `CHK(operand_wait, 1'h1)
      put(1'h1, {scs_pkg::OPC_IMMEDIATE_PREFIX, 4'(n)});
      `CHK(operand_wait, 1'h0)
      `CHK(skip_pending, 1'h1)
      put(1'h1, scs_pkg::OPC_SET_CARRY);
      `CHK(skipped, 1'h1)
      `CHK(carry_flag, 1'h0)
      acc_set = 4'(n) ^ 4'h9;
      put(1'h1, scs_pkg::OPC_COMPARE_IMMEDIATE_SKIP);
      put(1'h1, {scs_pkg::OPC_IMMEDIATE_PREFIX, 4'(n)});
      `CHK(skip_pending, 1'h0)
      `CHK(carry_flag, 1'h0)
      put(1'h1, scs_pkg::OPC_SET_SINGLE_PORT);
      `CHK(skipped, 1'h0)
      `CHK(set_single_port, 1'h1)
    end
    $display("Test compare done");
  endtask : test_compare

  task automatic test_carry;
    put(1'h0, scs_pkg::OPC_SET_CARRY);
    `CHK(carry_flag, 1'h0)
    put(1'h1, scs_pkg::OPC_SET_CARRY);
    `CHK(carry_flag, 1'h1)
    `CHK(skip_pending, 1'h0)
    acc_set = 4'h3;
    put(1'h1, scs_pkg::OPC_COMPARE_IMMEDIATE_SKIP);
    put(1'h1, {scs_pkg::OPC_IMMEDIATE_PREFIX, 4'hC});
    `CHK(carry_flag, 1'h1)
    `CHK(skip_pending, 1'h0)
    $display("Test carry done");
  endtask : test_carry

  task automatic test_indexed;
    logic [7:0] exp;
    exp = 8'h00;
    acc_set = 4'h6;
    put(1'h1, scs_pkg::OPC_COMPARE_IMMEDIATE_SKIP);
    put(1'h1, {scs_pkg::OPC_IMMEDIATE_PREFIX, 4'h6});
    yptr_set = 4'h7;
    put(1'h1, scs_pkg::OPC_SET_INDEXED_PORT_BIT);
    `CHK(indexed_port, exp)
    // Y kept within 0 to 7
    for (int y = 0; y < 8; y++)
    begin
      yptr_set = 4'(y);
      exp[y] = 1'h1;
      put(1'h1, scs_pkg::OPC_SET_INDEXED_PORT_BIT);
      `CHK(indexed_port, exp)
      `CHK(skip_pending, 1'h0)
    end
    $display("Test indexed done");
  endtask : test_indexed

  task automatic test_reset;
    @(negedge core_clk);
    instr = '{valid: 1'h0, word: 10'h000};
    sys_rst = 1'h1;
    #1;
    `CHK({carry_flag, set_single_port, indexed_port, operand_wait, skip_pending, skipped}, 13'h0000)
    @(negedge core_clk);
    sys_rst = 1'h0;
    put(1'h1, scs_pkg::OPC_SET_SINGLE_PORT);
    `CHK(set_single_port, 1'h1)
    `CHK(carry_flag, 1'h0)
    $display("Test reset done");
  endtask : test_reset

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    err_total = 0;
    n_compared = 0;
    sys_rst = 1'h1;
    instr = '{valid: 1'h0, word: 10'h000};
    acc = 4'h0;
    yptr = 4'h0;
    acc_set = 4'h0;
    yptr_set = 4'h0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK({carry_flag, set_single_port, indexed_port, operand_wait, skip_pending, skipped}, 13'h0000)
    @(negedge core_clk);
    sys_rst = 1'h0;
    test_compare();
    test_carry();
    test_indexed();
    test_reset();
    give_verdict();
  end

  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule : testbench
